// ---- logic/tsense_regs.sv ----
// two-wire target register bank of the temperature sensor with general-call reset
// Overview of operation
// RULE_01: general-call reset command starts a full internal reset lasting about 1.5 ms.
// RULE_02: when that reset ends, a temperature sample starts at once with current settings.
// RULE_03: controller sets sixteen-second cycles, distinct addresses, resets, reads within 16 s.
// RULE_04: upper threshold at address 2, read-write, defaults to 0x6000.
// RULE_05: lower threshold at address 3, read-write, defaults to 0x8000.
// RULE_06: backed register defaults come from programmable nonvolatile cells.
// RULE_07: result register is read-only, newest result, 0x8000 until first conversion.
// RULE_08: temperatures are 16-bit two's complement, 0.0078125 degrees per step.
module tsense_regs #(
    parameter int GC_RESET_CYCLES = tsense_pkg::GC_RESET_CYCLES,
    parameter logic [15:0] PART_ID = tsense_pkg::PART_ID_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] addr_sel,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    output logic conv_start,
    output logic internal_reset_busy,
    output logic [15:0] configuration_word,
    output logic [15:0] upper_threshold_word,
    output logic [15:0] lower_threshold_word,
    output logic [15:0] offset_word
);

    // ------------------------------------------------------------
    // bus edge detection
    // ------------------------------------------------------------
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_in;
            sda_d_reg <= sda_in;
        end
    end

    assign scl_rise = scl_in & ~scl_d_reg;
    assign scl_fall = ~scl_in & scl_d_reg;
    assign start_cond = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    assign stop_cond = scl_in & scl_d_reg & ~sda_d_reg & sda_in;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    tsense_pkg::bus_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [15:0] tx_word_reg;
    logic [7:0] pointer_reg;
    logic [7:0] hi_byte_reg;
    logic [1:0] wcnt_reg;
    logic rw_reg;
    logic gc_reg;
    logic low_byte_reg;
    logic nack_reg;
    logic oe_reg;
    logic gc_cmd_reg;
    logic wr_valid_reg;
    tsense_pkg::reg_wr_t wr_reg;
    logic [15:0] rd_word;
    logic gc_busy;
    logic gc_done;
    logic load_reg;
    logic reload;
    logic [tsense_pkg::NV_CELLS-1:0][15:0] nv_cells;
    logic nv_hit;
    logic [2:0] nv_idx;
    logic [15:0] result_reg;
    logic [15:0] config_reg;
    logic [15:0] upper_reg;
    logic [15:0] lower_reg;
    logic [15:0] unlock_reg;
    logic [15:0] word1_reg;
    logic [15:0] word2_reg;
    logic [15:0] offset_reg;
    logic [15:0] word3_reg;

    // ------------------------------------------------------------
    // bus target state machine
    // ------------------------------------------------------------
    // the bus is ignored while the internal reset runs, so the device answers no address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= tsense_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_word_reg <= 16'h0000;
            pointer_reg <= 8'h00;
            hi_byte_reg <= 8'h00;
            wcnt_reg <= 2'h0;
            rw_reg <= 1'b0;
            gc_reg <= 1'b0;
            low_byte_reg <= 1'b0;
            nack_reg <= 1'b0;
            oe_reg <= 1'b0;
            gc_cmd_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_reg <= '0;
        end else begin
            gc_cmd_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            if (gc_busy || stop_cond) begin
                state_reg <= tsense_pkg::ST_IDLE;
                oe_reg <= 1'b0;
            end else if (start_cond) begin
                state_reg <= tsense_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                oe_reg <= 1'b0;
            end else if (scl_rise) begin
                unique case (state_reg)
                    tsense_pkg::ST_ADDR, tsense_pkg::ST_WBYTE: begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    tsense_pkg::ST_RBYTE: begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    tsense_pkg::ST_RACK: begin
                        nack_reg <= sda_in;
                    end
                    tsense_pkg::ST_IDLE, tsense_pkg::ST_ADDR_ACK, tsense_pkg::ST_WACK: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state_reg)
                    tsense_pkg::ST_ADDR: begin
                        if (bit_cnt_reg == tsense_pkg::BITS_PER_BYTE) begin
                            wcnt_reg <= 2'h0;
                            if (shift_reg[7:1] == (tsense_pkg::TARGET_ADDR_BASE | {5'h00, addr_sel})) begin
                                rw_reg <= shift_reg[0];
                                gc_reg <= 1'b0;
                                oe_reg <= 1'b1;
                                state_reg <= tsense_pkg::ST_ADDR_ACK;
                            end else if (shift_reg == tsense_pkg::GENERAL_CALL_ADDR) begin
                                rw_reg <= 1'b0;
                                gc_reg <= 1'b1;
                                oe_reg <= 1'b1;
                                state_reg <= tsense_pkg::ST_ADDR_ACK;
                            end else begin
                                state_reg <= tsense_pkg::ST_IDLE;
                            end
                        end
                    end
                    tsense_pkg::ST_ADDR_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            low_byte_reg <= 1'b0;
                            oe_reg <= ~rd_word[15];
                            tx_word_reg <= {rd_word[14:0], 1'b0};
                            state_reg <= tsense_pkg::ST_RBYTE;
                        end else begin
                            oe_reg <= 1'b0;
                            state_reg <= tsense_pkg::ST_WBYTE;
                        end
                    end
                    tsense_pkg::ST_WBYTE: begin
                        if (bit_cnt_reg == tsense_pkg::BITS_PER_BYTE) begin
                            oe_reg <= 1'b1;
                            state_reg <= tsense_pkg::ST_WACK;
                            if (gc_reg) begin
                                gc_cmd_reg <= (shift_reg == tsense_pkg::GENERAL_CALL_RESET);
                            end else if (wcnt_reg == 2'h0) begin
                                pointer_reg <= shift_reg;
                                wcnt_reg <= 2'h1;
                            end else if (wcnt_reg == 2'h1) begin
                                hi_byte_reg <= shift_reg;
                                wcnt_reg <= 2'h2;
                            end else begin
                                wr_valid_reg <= 1'b1;
                                wr_reg <= '{addr: pointer_reg, data: {hi_byte_reg, shift_reg}};
                                wcnt_reg <= 2'h1;
                            end
                        end
                    end
                    tsense_pkg::ST_WACK: begin
                        oe_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= tsense_pkg::ST_WBYTE;
                    end
                    tsense_pkg::ST_RBYTE: begin
                        if (bit_cnt_reg == tsense_pkg::BITS_PER_BYTE) begin
                            oe_reg <= 1'b0;
                            state_reg <= tsense_pkg::ST_RACK;
                        end else begin
                            oe_reg <= ~tx_word_reg[15];
                            tx_word_reg <= {tx_word_reg[14:0], 1'b0};
                        end
                    end
                    tsense_pkg::ST_RACK: begin
                        if (nack_reg) begin
                            state_reg <= tsense_pkg::ST_IDLE;
                        end else begin
                            // a word is re-fetched after its low byte so repeated reads stay fresh
                            bit_cnt_reg <= 4'h0;
                            state_reg <= tsense_pkg::ST_RBYTE;
                            low_byte_reg <= ~low_byte_reg;
                            if (low_byte_reg) begin
                                oe_reg <= ~rd_word[15];
                                tx_word_reg <= {rd_word[14:0], 1'b0};
                            end else begin
                                oe_reg <= ~tx_word_reg[15];
                                tx_word_reg <= {tx_word_reg[14:0], 1'b0};
                            end
                        end
                    end
                    tsense_pkg::ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;

    // ------------------------------------------------------------
    // internal reset and default reload
    // ------------------------------------------------------------
    gc_reset_timer #(
        .CYCLES(GC_RESET_CYCLES)
    ) u_gc_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(gc_cmd_reg), // [RULE_01]
        .busy(gc_busy),
        .done(gc_done)
    );

    // one extra load after rst, since the cells themselves reset in that same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            load_reg <= 1'b1;
        end else begin
            load_reg <= 1'b0;
        end
    end

    assign reload = load_reg | gc_busy;

    always_comb begin
        nv_hit = 1'b1;
        nv_idx = tsense_pkg::NV_IDX_CONFIGURATION;
        unique case (wr_reg.addr)
            tsense_pkg::OFS_DEVICE_CONFIGURATION: nv_idx = tsense_pkg::NV_IDX_CONFIGURATION;
            tsense_pkg::OFS_UPPER_THRESHOLD: nv_idx = tsense_pkg::NV_IDX_UPPER;
            tsense_pkg::OFS_LOWER_THRESHOLD: nv_idx = tsense_pkg::NV_IDX_LOWER;
            tsense_pkg::OFS_NV_GENERAL_WORD_1: nv_idx = tsense_pkg::NV_IDX_WORD_1;
            tsense_pkg::OFS_NV_GENERAL_WORD_2: nv_idx = tsense_pkg::NV_IDX_WORD_2;
            tsense_pkg::OFS_TEMPERATURE_OFFSET: nv_idx = tsense_pkg::NV_IDX_OFFSET;
            tsense_pkg::OFS_NV_GENERAL_WORD_3: nv_idx = tsense_pkg::NV_IDX_WORD_3;
            default: nv_hit = 1'b0;
        endcase
    end

    nv_default_store u_nv (
        .sys_clk(sys_clk),
        .rst(rst),
        .prog_we(wr_valid_reg & nv_hit & unlock_reg[tsense_pkg::NV_UNLOCK_BIT]), // [RULE_06]
        .prog_idx(nv_idx),
        .prog_data(wr_reg.data),
        .cells(nv_cells)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            config_reg <= tsense_pkg::RST_DEVICE_CONFIGURATION;
            upper_reg <= tsense_pkg::RST_UPPER_THRESHOLD; // [RULE_04]
            lower_reg <= tsense_pkg::RST_LOWER_THRESHOLD; // [RULE_05]
            unlock_reg <= tsense_pkg::RST_NV_UNLOCK_CONTROL;
            word1_reg <= tsense_pkg::RST_NV_GENERAL_WORD;
            word2_reg <= tsense_pkg::RST_NV_GENERAL_WORD;
            offset_reg <= tsense_pkg::RST_TEMPERATURE_OFFSET;
            word3_reg <= tsense_pkg::RST_NV_GENERAL_WORD;
        end else if (reload) begin
            config_reg <= nv_cells[tsense_pkg::NV_IDX_CONFIGURATION]; // [RULE_06]
            upper_reg <= nv_cells[tsense_pkg::NV_IDX_UPPER]; // [RULE_04] [RULE_06]
            lower_reg <= nv_cells[tsense_pkg::NV_IDX_LOWER]; // [RULE_05] [RULE_06]
            unlock_reg <= tsense_pkg::RST_NV_UNLOCK_CONTROL;
            word1_reg <= nv_cells[tsense_pkg::NV_IDX_WORD_1];
            word2_reg <= nv_cells[tsense_pkg::NV_IDX_WORD_2];
            offset_reg <= nv_cells[tsense_pkg::NV_IDX_OFFSET];
            word3_reg <= nv_cells[tsense_pkg::NV_IDX_WORD_3];
        end else if (wr_valid_reg) begin
            unique case (wr_reg.addr)
                tsense_pkg::OFS_DEVICE_CONFIGURATION: config_reg <= wr_reg.data;
                tsense_pkg::OFS_UPPER_THRESHOLD: upper_reg <= wr_reg.data; // [RULE_04]
                tsense_pkg::OFS_LOWER_THRESHOLD: lower_reg <= wr_reg.data; // [RULE_05]
                tsense_pkg::OFS_NV_UNLOCK_CONTROL: unlock_reg <= wr_reg.data;
                tsense_pkg::OFS_NV_GENERAL_WORD_1: word1_reg <= wr_reg.data;
                tsense_pkg::OFS_NV_GENERAL_WORD_2: word2_reg <= wr_reg.data;
                tsense_pkg::OFS_TEMPERATURE_OFFSET: offset_reg <= wr_reg.data;
                tsense_pkg::OFS_NV_GENERAL_WORD_3: word3_reg <= wr_reg.data;
                default: begin
                end
            endcase
        end
    end

    // result is kept as the raw two's complement code; no scaling inside the bank
    always_ff @(posedge sys_clk) begin
        if (rst || reload) begin
            result_reg <= tsense_pkg::RST_TEMPERATURE_RESULT; // [RULE_07]
        end else if (conv_done) begin
            result_reg <= conv_result; // [RULE_07] [RULE_08]
        end
    end

    always_comb begin
        rd_word = 16'h0000;
        unique case (pointer_reg)
            tsense_pkg::OFS_TEMPERATURE_RESULT: rd_word = result_reg;
            tsense_pkg::OFS_DEVICE_CONFIGURATION: rd_word = config_reg;
            tsense_pkg::OFS_UPPER_THRESHOLD: rd_word = upper_reg;
            tsense_pkg::OFS_LOWER_THRESHOLD: rd_word = lower_reg;
            tsense_pkg::OFS_NV_UNLOCK_CONTROL: rd_word = unlock_reg;
            tsense_pkg::OFS_NV_GENERAL_WORD_1: rd_word = word1_reg;
            tsense_pkg::OFS_NV_GENERAL_WORD_2: rd_word = word2_reg;
            tsense_pkg::OFS_TEMPERATURE_OFFSET: rd_word = offset_reg;
            tsense_pkg::OFS_NV_GENERAL_WORD_3: rd_word = word3_reg;
            tsense_pkg::OFS_PART_IDENTIFICATION: rd_word = PART_ID;
            default: rd_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign conv_start = gc_done; // [RULE_02]
    assign internal_reset_busy = gc_busy;
    assign configuration_word = config_reg;
    assign upper_threshold_word = upper_reg;
    assign lower_threshold_word = lower_reg;
    assign offset_word = offset_reg;

endmodule : tsense_regs

// ---- logic/tsense_pkg.sv ----
// shared constants, types and state codes for the temperature sensor register bank
package tsense_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TEMPERATURE_RESULT = 8'h00;
    localparam logic [7:0] OFS_DEVICE_CONFIGURATION = 8'h01;
    localparam logic [7:0] OFS_UPPER_THRESHOLD = 8'h02;
    localparam logic [7:0] OFS_LOWER_THRESHOLD = 8'h03;
    localparam logic [7:0] OFS_NV_UNLOCK_CONTROL = 8'h04;
    localparam logic [7:0] OFS_NV_GENERAL_WORD_1 = 8'h05;
    localparam logic [7:0] OFS_NV_GENERAL_WORD_2 = 8'h06;
    localparam logic [7:0] OFS_TEMPERATURE_OFFSET = 8'h07;
    localparam logic [7:0] OFS_NV_GENERAL_WORD_3 = 8'h08;
    localparam logic [7:0] OFS_PART_IDENTIFICATION = 8'h0f;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_TEMPERATURE_RESULT = 16'h8000;
    localparam logic [15:0] RST_DEVICE_CONFIGURATION = 16'h0220;
    localparam logic [15:0] RST_UPPER_THRESHOLD = 16'h6000;
    localparam logic [15:0] RST_LOWER_THRESHOLD = 16'h8000;
    localparam logic [15:0] RST_NV_UNLOCK_CONTROL = 16'h0000;
    localparam logic [15:0] RST_NV_GENERAL_WORD = 16'h0000;
    localparam logic [15:0] RST_TEMPERATURE_OFFSET = 16'h0000;
    // arbitrary neutral identification value
    localparam logic [15:0] PART_ID_DEFAULT = 16'h5a3c;

    // unlock field: writes to backed registers also program the cells
    localparam int NV_UNLOCK_BIT = 15;

    // ------------------------------------------------------------
    // nonvolatile cell layout
    // ------------------------------------------------------------
    localparam int NV_CELLS = 7;
    localparam logic [2:0] NV_IDX_CONFIGURATION = 3'h0;
    localparam logic [2:0] NV_IDX_UPPER = 3'h1;
    localparam logic [2:0] NV_IDX_LOWER = 3'h2;
    localparam logic [2:0] NV_IDX_WORD_1 = 3'h3;
    localparam logic [2:0] NV_IDX_WORD_2 = 3'h4;
    localparam logic [2:0] NV_IDX_OFFSET = 3'h5;
    localparam logic [2:0] NV_IDX_WORD_3 = 3'h6;
    localparam logic [NV_CELLS-1:0][15:0] NV_FACTORY = {
        RST_NV_GENERAL_WORD, RST_TEMPERATURE_OFFSET, RST_NV_GENERAL_WORD,
        RST_NV_GENERAL_WORD, RST_LOWER_THRESHOLD, RST_UPPER_THRESHOLD,
        RST_DEVICE_CONFIGURATION};

    // ------------------------------------------------------------
    // two-wire bus
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h48;
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [7:0] GENERAL_CALL_RESET = 8'h06;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int GC_RESET_TIME_NS = 1500000;
    localparam int GC_RESET_CYCLES = (GC_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } reg_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_WBYTE = 3'b010,
        ST_WACK = 3'b110,
        ST_RBYTE = 3'b111,
        ST_RACK = 3'b101
    } bus_state_t;

endpackage : tsense_pkg

// ---- logic/gc_reset_timer.sv ----
// internal reset sequencer started by the general-call reset command
module gc_reset_timer #(
    parameter int CYCLES = tsense_pkg::GC_RESET_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    output logic busy,
    output logic done
);

    logic [17:0] cnt_reg;
    logic busy_reg;
    logic done_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= 18'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                busy_reg <= 1'b1;
                cnt_reg <= 18'h0;
            end else if (busy_reg) begin
                if (cnt_reg == 18'(CYCLES - 1)) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 18'h1;
                end
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule : gc_reset_timer

// ---- logic/nv_default_store.sv ----
// factory-programmed cells holding the reset defaults of the backed registers
module nv_default_store (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic prog_we,
    input wire logic [2:0] prog_idx,
    input wire logic [15:0] prog_data,
    output logic [tsense_pkg::NV_CELLS-1:0][15:0] cells
);

    logic [tsense_pkg::NV_CELLS-1:0][15:0] cell_reg;

    // rst stands for power-up with factory contents; the general-call reset keeps them
    for (genvar i = 0; i < tsense_pkg::NV_CELLS; i++) begin : g_cell
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                cell_reg[i] <= tsense_pkg::NV_FACTORY[i];
            end else if (prog_we && prog_idx == 3'(i)) begin
                cell_reg[i] <= prog_data;
            end
        end
    end

    assign cells = cell_reg;

endmodule : nv_default_store

// ---- test/twi_host.sv ----
// two-wire bus controller model that drives the sensor's bus pins
module twi_host #(
    parameter logic [6:0] ADDR = 7'h49
) (
    input wire logic sys_clk,
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    initial scl = 1'b1;
    // open drain with pull-up: a released line reads high
    assign sda_in = drv & ~(sda_oe & ~sda_out);
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic bit_io(input logic b, output logic r);
        drv <= b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        r = sda_in;
        scl <= 1'b0;
        tick(2);
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(last, k);
    endtask : xfer
    task automatic start();
        drv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        drv <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask : start
    task automatic stop();
        drv <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        drv <= 1'b1;
        tick(4);
    endtask : stop
    // gc sends the general-call reset; the bench leaves the bus idle afterwards
    task automatic wr(input tsense_pkg::reg_wr_t w, input logic gc);
        logic [7:0] q;
        start();
        xfer(gc ? tsense_pkg::GENERAL_CALL_ADDR : {ADDR, 1'b0}, 1'b1, q);
        xfer(w.addr, 1'b1, q);
        if (!gc) begin
            xfer(w.data[15:8], 1'b1, q);
            xfer(w.data[7:0], 1'b1, q);
        end
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        logic [7:0] q;
        start();
        xfer({ADDR, 1'b0}, 1'b1, q);
        xfer(p, 1'b1, q);
        start();
        xfer({ADDR, 1'b1}, 1'b1, q);
        xfer(8'hff, 1'b0, d[15:8]);
        xfer(8'hff, 1'b1, d[7:0]);
        stop();
    endtask : rd
endmodule : twi_host

// ---- test/tsense_regs_asserts.sv ----
// port checker for the sensor register bank
module tsense_regs_asserts #(
    parameter int GC_RESET_CYCLES = tsense_pkg::GC_RESET_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sda_oe,
    input wire logic conv_start,
    input wire logic internal_reset_busy,
    input wire logic [15:0] configuration_word,
    input wire logic [15:0] upper_threshold_word,
    input wire logic [15:0] lower_threshold_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    int busy_cnt;
    always_ff @(posedge sys_clk) begin
        busy_cnt <= (rst || !internal_reset_busy) ? 0 : busy_cnt + 1;
    end
    property p_busy_len; $rose(internal_reset_busy) |=> internal_reset_busy [*8]; endproperty
    a_busy_len: assert property (p_busy_len) else $error("reset too short");
    // one cycle of slack: the length is approximate
    property p_busy_cnt; $fell(internal_reset_busy) |->
        busy_cnt inside {[GC_RESET_CYCLES - 1 : GC_RESET_CYCLES + 1]}; endproperty
    a_busy_cnt: assert property (p_busy_cnt) else $error("reset length off");
    property p_start_end; $fell(internal_reset_busy) |-> conv_start; endproperty
    a_start_end: assert property (p_start_end) else $error("no sample start");
    property p_start_only; conv_start |-> $fell(internal_reset_busy); endproperty
    a_start_only: assert property (p_start_only) else $error("stray start");
    property p_up_rst; $past(rst) |-> upper_threshold_word == 16'h6000; endproperty
    a_up_rst: assert property (p_up_rst) else $error("upper default");
    property p_lo_rst; $past(rst) |-> lower_threshold_word == 16'h8000; endproperty
    a_lo_rst: assert property (p_lo_rst) else $error("lower default");
    property p_cfg_rst; $past(rst) |-> configuration_word == 16'h0220; endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("config default");
    property p_reload; internal_reset_busy && $past(internal_reset_busy, 3) |->
        $stable(upper_threshold_word); endproperty
    a_reload: assert property (p_reload) else $error("word moved in reload");
    c_gc: cover property ($rose(internal_reset_busy));
    c_start: cover property (conv_start);
    c_ack: cover property ($rose(sda_oe));
endmodule : tsense_regs_asserts
bind tsense_regs tsense_regs_asserts #(.GC_RESET_CYCLES(GC_RESET_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .sda_oe(sda_oe), .conv_start(conv_start),
    .internal_reset_busy(internal_reset_busy), .configuration_word(configuration_word),
    .upper_threshold_word(upper_threshold_word), .lower_threshold_word(lower_threshold_word));

// ---- test/tb_top.sv ----
// self-checking bench for the sensor register bank
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GC = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic conv_done = 1'b0;
    logic scl, sda_in, sda_out, sda_oe, conv_start, busy;
    logic [15:0] conv_result = 16'h0000, cfg, up, lo, ofs, d;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0, nb = 0;
    always #5 sys_clk = ~sys_clk;
    // addr_sel must match the host model's address
    tsense_regs #(.GC_RESET_CYCLES(GC)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .addr_sel(2'h1), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
        .internal_reset_busy(busy), .configuration_word(cfg), .upper_threshold_word(up),
        .lower_threshold_word(lo), .offset_word(ofs));
    twi_host u_host (.sys_clk(sys_clk), .sda_oe(sda_oe), .sda_out(sda_out),
        .scl(scl), .sda_in(sda_in));
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    always @(negedge sys_clk) if (busy === 1'b1) nb++;
    task automatic rchk(input logic [7:0] p, input logic [15:0] e);
        u_host.rd(p, d);
        `CHK(d, e)
    endtask : rchk
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rchk(8'h00, 16'h8000);
        rchk(8'h01, 16'h0220);
        rchk(8'h02, 16'h6000);
        rchk(8'h03, 16'h8000);
        rchk(8'h07, 16'h0000);
        rchk(8'h0f, tsense_pkg::PART_ID_DEFAULT);
        rchk(8'h09, 16'h0000);
        $display("test defaults done");
        u_host.wr({8'h02, 16'h1234}, 1'b0);
        u_host.wr({8'h00, 16'hffff}, 1'b0);
        rchk(8'h02, 16'h1234);
        `CHK(up, 16'h1234)
        rchk(8'h00, 16'h8000);
        conv_result <= 16'hfe00;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        rchk(8'h00, 16'hfe00);
        $display("test access done");
        // unlocked write reaches the cell, the locked one does not
        u_host.wr({8'h04, 16'h8000}, 1'b0);
        u_host.wr({8'h02, 16'h2222}, 1'b0);
        u_host.wr({8'h04, 16'h0000}, 1'b0);
        u_host.wr({8'h03, 16'h1111}, 1'b0);
        nb = 0;
        u_host.wr({tsense_pkg::GENERAL_CALL_RESET, 16'h0000}, 1'b1);
        for (int i = 0; i < 200 && conv_start !== 1'b1; i++) @(negedge sys_clk);
        `CHK(conv_start, 1'b1)
        `CHK(nb, GC)
        rchk(8'h02, 16'h2222);
        rchk(8'h03, 16'h8000);
        `CHK(lo, 16'h8000)
        `CHK(ofs, 16'h0000)
        rchk(8'h00, 16'h8000);
        $display("test general call done");
        stop_test();
    end
endmodule : tb_top
